// ---- vfa_pkg.sv ----
// Constants, register map and state types of the voltage fluctuation analyser.
// Assumes a 125 MHz system clock and one AHB-Lite master.
// Summary of operation
// - Integrate squared samples over each half-cycle
// - Signed percent of nominal, positive below
// - Check against +-0.2% band, 1 s average
// - Steady after 1 s inside band
// - First out-of-band value starts change interval
// - Steady band centre tracks rolling average
// - Change band centre moves only on crossing
// - Keep largest step between steady levels
// - Accumulate time beyond 3.3% per change
// - Over-threshold time judged against 500 ms
// - Keep largest down and up deviation
// - Step change judged against 3.3% limit
// - Three results compared, drive pass flags
// - Long-term span twelve intervals, may be omitted
// - Current sensing forces 96 A range
// - Voltage sensing range free, overload aborts
// - Reject out-of-range impedance entries
// - Nominal voltage selects input range
// - Nominal frequency selects filter response
// - Current sensing uses 300 samples per cycle
// - Duration 600 s, or 7200 s with long-term
package vfa_pkg;
  localparam int unsigned CLK_HZ   = 125_000_000;
  localparam int          DIV_W    = 40;
  localparam logic [7:0]  A_CTRL   = 8'h00;
  localparam logic [7:0]  A_NOM    = 8'h04;
  localparam logic [7:0]  A_DLIM   = 8'h08;
  localparam logic [7:0]  A_RANGE  = 8'h0c;
  localparam logic [7:0]  A_IMPR   = 8'h10;
  localparam logic [7:0]  A_IMPX   = 8'h14;
  localparam logic [7:0]  A_STAT   = 8'h18;
  localparam logic [7:0]  A_DC     = 8'h1c;
  localparam logic [7:0]  A_MAX_RELATIVE_CHANGE   = 8'h20;
  localparam logic [7:0]  A_OVER_THRESHOLD_TIME   = 8'h24;
  localparam logic [7:0]  A_SECS   = 8'h28;
  localparam logic [7:0]  A_DNUP   = 8'h2c;
  localparam int          C_START  = 0;
  localparam int          C_STOP   = 1;
  localparam int          C_F60    = 2;
  localparam int          C_OMIT   = 3;
  localparam int          C_CUR    = 4;
  localparam logic [15:0] NOM_RST  = 16'h08fc;
  localparam logic [15:0] VSPLIT   = 16'h06d6;
  localparam logic [15:0] MAX_RELATIVE_CHANGE_RST = 16'h0190;
  localparam logic [15:0] DC_LIM   = 16'h014a;
  localparam logic [15:0] THR      = 16'h014a;
  localparam logic [15:0] BAND     = 16'h0014;
  localparam logic [29:0] PCT_SCL  = 30'h0000_2710;
  localparam logic [7:0]  RANGE_96 = 8'h60;
  localparam logic [15:0] IMP_MIN  = 16'h0001;
  localparam logic [15:0] IMP_MAX  = 16'h0fa0;
  localparam logic [15:0] IMPR_RST = 16'h0190;
  localparam logic [15:0] IMPX_RST = 16'h00fa;
  localparam int          WIN_S    = 1;
  localparam logic [6:0]  HC_50    = 7'(2 * 50 * WIN_S);
  localparam logic [6:0]  HC_60    = 7'(2 * 60 * WIN_S);
  localparam int          OVER_THRESHOLD_TIME_MS  = 500;
  localparam logic [15:0] TLIM_50  = 16'(OVER_THRESHOLD_TIME_MS * 2 * 50 / 1000);
  localparam logic [15:0] TLIM_60  = 16'(OVER_THRESHOLD_TIME_MS * 2 * 60 / 1000);
  localparam logic [12:0] DUR_S    = 13'h0258;
  localparam logic [12:0] DUR_L    = 13'h1c20;
  localparam int          PST_N    = 12;
  localparam int          SPC      = 300;
  localparam logic [15:0] SDIV_50  = 16'(CLK_HZ / (SPC * 50));
  localparam logic [15:0] SDIV_60  = 16'(CLK_HZ / (SPC * 60));
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b000, SQ_MS = 3'b001, SQ_ROOT = 3'b011,
    SQ_PCT  = 3'b010, SQ_AVG = 3'b110, SQ_CLS = 3'b100
  } vfa_seq_t;
  typedef enum logic {CL_CHANGE = 1'b0, CL_STEADY = 1'b1} vfa_cls_t;
endpackage

// ---- vfa_div.sv ----
// Sequential restoring unsigned divider, one quotient bit per clock.
// Assumes start is a single-cycle pulse given while idle.
`timescale 1ns/10ps
module vfa_div
  import vfa_pkg::*;
(
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic             start_in,
  input  wire logic [DIV_W-1:0] num_in,
  input  wire logic [DIV_W-1:0] den_in,
  output logic                  done_out,
  output logic      [DIV_W-1:0] quot_out
);
  logic [DIV_W:0]   rem_q;
  logic [DIV_W-1:0] den_q;
  logic [5:0]       cnt_q;
  logic             busy_q;
  logic [DIV_W:0]   trial;

  assign trial = {rem_q[DIV_W-1:0], quot_out[DIV_W-1]};

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rem_q    <= '0;
      den_q    <= '0;
      cnt_q    <= '0;
      busy_q   <= 1'b0;
      done_out <= 1'b0;
      quot_out <= '0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        rem_q    <= '0;
        den_q    <= den_in;
        quot_out <= num_in;
        cnt_q    <= 6'(DIV_W);
        busy_q   <= 1'b1;
      end else if (busy_q) begin
        if (trial >= {1'b0, den_q}) begin
          rem_q    <= trial - {1'b0, den_q};
          quot_out <= {quot_out[DIV_W-2:0], 1'b1};
        end else begin
          rem_q    <= trial;
          quot_out <= {quot_out[DIV_W-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy_q   <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- vfa_top.sv ----
// Half-cycle rms, percent deviation, steady state and change analysis with AHB-Lite registers.
// Assumes samples arrive on the system clock with a valid strobe; overload comes from a pin.
`timescale 1ns/10ps
module vfa_top
  import vfa_pkg::*;
#(
  parameter int unsigned SEC_CYC = CLK_HZ
)(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        smp_valid_in,
  input  wire logic [15:0] smp_in,
  input  wire logic        overload_in,
  output logic      [7:0]  range_out,
  output logic             vrange_hi_out,
  output logic             filt_60_out,
  output logic      [15:0] smp_div_out,
  output logic             steady_out,
  output logic             running_out,
  output logic      [2:0]  pass_out
);
  // Overload pin synchroniser
  logic [2:0] ovl_sync_q;
  logic       ovl_q;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ovl_sync_q <= '0;
      ovl_q      <= 1'b0;
    end else begin
      ovl_sync_q <= {ovl_sync_q[1:0], overload_in};
      if (ovl_sync_q[1] == ovl_sync_q[2]) ovl_q <= ovl_sync_q[2];
    end
  end

  function automatic logic [15:0] mag16(input logic signed [16:0] v);
    logic [16:0] m;
    m = v[16] ? 17'(-v) : 17'(v);
    return (m[16] | m[15]) ? 16'h7fff : m[15:0];
  endfunction

  // Bus slave and configuration
  logic        wr_q;
  logic [7:0]  wa_q;
  logic        f60_q, omit_q, cur_q, start_q, stop_q, imp_rej_q;
  logic [15:0] nom_q, dlim_q, impr_q, impx_q;
  logic [7:0]  range_q;
  logic [31:0] rd_d;
  logic        acc;
  logic        imp_ok;
  assign acc    = hsel_in & htrans_in[1] & hready_in;
  assign imp_ok = hwdata_in[15:0] >= IMP_MIN && hwdata_in[15:0] <= IMP_MAX;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wr_q      <= 1'b0;
      wa_q      <= '0;
      f60_q     <= 1'b0;
      omit_q    <= 1'b0;
      cur_q     <= 1'b0;
      start_q   <= 1'b0;
      stop_q    <= 1'b0;
      nom_q     <= NOM_RST;
      dlim_q    <= MAX_RELATIVE_CHANGE_RST;
      impr_q    <= IMPR_RST;
      impx_q    <= IMPX_RST;
      imp_rej_q <= 1'b0;
      range_q   <= RANGE_96;
    end else begin
      wr_q    <= acc & hwrite_in;
      start_q <= 1'b0;
      stop_q  <= 1'b0;
      if (acc) wa_q <= haddr_in[7:0];
      if (wr_q && wa_q == A_CTRL) begin
        start_q <= hwdata_in[C_START];
        stop_q  <= hwdata_in[C_STOP];
        f60_q   <= hwdata_in[C_F60];
        omit_q  <= hwdata_in[C_OMIT];
        cur_q   <= hwdata_in[C_CUR];
      end
      if (wr_q && wa_q == A_NOM) nom_q <= hwdata_in[15:0];
      if (wr_q && wa_q == A_DLIM) dlim_q <= hwdata_in[15:0];
      if (wr_q && (wa_q == A_IMPR || wa_q == A_IMPX)) begin
        imp_rej_q <= !imp_ok;
        if (imp_ok && wa_q == A_IMPR) impr_q <= hwdata_in[15:0];
        if (imp_ok && wa_q == A_IMPX) impx_q <= hwdata_in[15:0];
      end
      if (cur_q) range_q <= RANGE_96;
      else if (wr_q && wa_q == A_RANGE) range_q <= hwdata_in[7:0];
    end
  end

  // Derived pin-level selections
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      range_out     <= RANGE_96;
      vrange_hi_out <= 1'b1;
      filt_60_out   <= 1'b0;
      smp_div_out   <= SDIV_50;
    end else begin
      range_out     <= range_q;
      vrange_hi_out <= nom_q >= VSPLIT;
      filt_60_out   <= f60_q;
      smp_div_out   <= f60_q ? SDIV_60 : SDIV_50;
    end
  end

  // Test timing
  logic        run_q, done_q, abort_q;
  logic [31:0] tick_q;
  logic [12:0] secs_q;
  logic [12:0] dur;
  assign dur = omit_q ? DUR_S : DUR_L;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      run_q   <= 1'b0;
      done_q  <= 1'b0;
      abort_q <= 1'b0;
      tick_q  <= '0;
      secs_q  <= '0;
    end else if (start_q) begin
      run_q   <= 1'b1;
      done_q  <= 1'b0;
      abort_q <= 1'b0;
      tick_q  <= '0;
      secs_q  <= '0;
    end else if (run_q) begin
      if (ovl_q || stop_q) begin
        run_q   <= 1'b0;
        abort_q <= 1'b1;
      end else if (tick_q == SEC_CYC - 1) begin
        tick_q <= '0;
        secs_q <= secs_q + 13'h0001;
        if (secs_q + 13'h0001 == dur) begin
          run_q  <= 1'b0;
          done_q <= 1'b1;
        end
      end else begin
        tick_q <= tick_q + 32'h1;
      end
    end else if (stop_q) begin
      done_q  <= 1'b0;
      abort_q <= 1'b0;
      secs_q  <= '0;
    end
  end

  // Half-cycle square integration
  logic              prev_neg_q, bnd_q;
  logic [DIV_W-1:0]  acc_q, hsum_q;
  logic [9:0]        cnt_q, hcnt_q;
  logic [29:0]       sq;
  assign sq = 30'($signed(smp_in) * $signed(smp_in));
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      prev_neg_q <= 1'b0;
      bnd_q      <= 1'b0;
      acc_q      <= '0;
      cnt_q      <= '0;
      hsum_q     <= '0;
      hcnt_q     <= 10'h001;
    end else begin
      bnd_q <= 1'b0;
      if (smp_valid_in) begin
        prev_neg_q <= smp_in[15];
        if (smp_in[15] != prev_neg_q && cnt_q != 10'h000) begin
          bnd_q  <= 1'b1;
          hsum_q <= acc_q;
          hcnt_q <= cnt_q;
          acc_q  <= DIV_W'(sq);
          cnt_q  <= 10'h001;
        end else if (cnt_q != 10'h3ff) begin
          acc_q <= acc_q + DIV_W'(sq);
          cnt_q <= cnt_q + 10'h001;
        end
      end
    end
  end

  // Arithmetic sequencer: mean square, root, percent, rolling average
  vfa_seq_t          st_q;
  logic              dgo_q, ddone, neg_q, cls_go;
  logic [DIV_W-1:0]  dn_q, dd_q, quot;
  logic [31:0]       ms_q;
  logic [15:0]       root_q, root_d, trial;
  logic [3:0]        bit_q;
  logic signed [15:0] pct_q, avg_q;
  logic signed [23:0] sum_q;
  logic [6:0]        fill_q;
  logic [15:0]       qsat;
  assign trial  = root_q | (16'h0001 << bit_q);
  assign root_d = (32'(trial) * 32'(trial) <= ms_q) ? trial : root_q;
  assign qsat   = quot[DIV_W-1:15] != '0 ? 16'h7fff : quot[15:0];
  assign cls_go = st_q == SQ_CLS;

  vfa_div u_div (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .start_in   (dgo_q),
    .num_in     (dn_q),
    .den_in     (dd_q),
    .done_out   (ddone),
    .quot_out   (quot)
  );

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      st_q   <= SQ_IDLE;
      dgo_q  <= 1'b0;
      dn_q   <= '0;
      dd_q   <= '0;
      ms_q   <= '0;
      root_q <= '0;
      bit_q  <= '0;
      neg_q  <= 1'b0;
      pct_q  <= '0;
      avg_q  <= '0;
    end else begin
      dgo_q <= 1'b0;
      unique case (st_q)
        SQ_IDLE: if (bnd_q) begin
          dn_q  <= hsum_q;
          dd_q  <= DIV_W'(hcnt_q);
          dgo_q <= 1'b1;
          st_q  <= SQ_MS;
        end
        SQ_MS: if (ddone) begin
          ms_q   <= quot[DIV_W-1:32] != '0 ? 32'hffff_ffff : quot[31:0];
          root_q <= '0;
          bit_q  <= 4'hf;
          st_q   <= SQ_ROOT;
        end
        SQ_ROOT: begin
          root_q <= root_d;
          bit_q  <= bit_q - 4'h1;
          if (bit_q == 4'h0) begin
            neg_q <= root_d > nom_q;
            dn_q  <= DIV_W'(30'(mag16(17'($signed({1'b0, nom_q})) - 17'($signed({1'b0, root_d})))) * PCT_SCL);
            dd_q  <= DIV_W'(nom_q);
            dgo_q <= 1'b1;
            st_q  <= SQ_PCT;
          end
        end
        SQ_PCT: if (ddone) begin
          pct_q <= neg_q ? -$signed(qsat) : $signed(qsat);
          neg_q <= sum_q[23];
          dn_q  <= DIV_W'(sum_q[23] ? -sum_q : sum_q);
          dd_q  <= DIV_W'(fill_q == 7'h00 ? 7'h01 : fill_q);
          dgo_q <= 1'b1;
          st_q  <= SQ_AVG;
        end
        SQ_AVG: if (ddone) begin
          avg_q <= neg_q ? -$signed(qsat) : $signed(qsat);
          st_q  <= SQ_CLS;
        end
        SQ_CLS: st_q <= SQ_IDLE;
        default: st_q <= SQ_IDLE;
      endcase
    end
  end

  // Steady state and change interval classification
  logic signed [15:0] win_q [0:119];
  logic [6:0]         wi_q, inb_q, nhc;
  vfa_cls_t           cls_q;
  logic signed [15:0] ctr_q, sse_q, ref_v;
  logic               have_q, out_b;
  logic [15:0]        dc_q, dnx_q, upx_q, tcur_q, over_threshold_time_q, tlim;
  logic signed [16:0] dv, dd;
  assign nhc   = f60_q ? HC_60 : HC_50;
  assign ref_v = fill_q == 7'h00 ? pct_q : avg_q;
  assign dv    = 17'(pct_q) - 17'(ctr_q);
  assign dd    = 17'(pct_q) - 17'(sse_q);
  assign out_b = mag16(dv) > BAND;
  assign tlim  = f60_q ? TLIM_60 : TLIM_50;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wi_q   <= '0;
      fill_q <= '0;
      sum_q  <= '0;
    end else if (start_q) begin
      wi_q   <= '0;
      fill_q <= '0;
      sum_q  <= '0;
    end else if (cls_go && run_q) begin
      win_q[wi_q] <= pct_q;
      wi_q        <= wi_q + 7'h01 == nhc ? 7'h00 : wi_q + 7'h01;
      if (fill_q == nhc) sum_q <= sum_q + 24'(pct_q) - 24'(win_q[wi_q]);
      else begin
        sum_q  <= sum_q + 24'(pct_q);
        fill_q <= fill_q + 7'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || start_q) begin
      cls_q  <= CL_CHANGE;
      ctr_q  <= '0;
      sse_q  <= '0;
      have_q <= 1'b0;
      inb_q  <= '0;
      dc_q   <= '0;
      dnx_q  <= '0;
      upx_q  <= '0;
      tcur_q <= '0;
      over_threshold_time_q <= '0;
    end else if (cls_go && run_q) begin
      if (cls_q == CL_STEADY) begin
        if (out_b) begin
          cls_q  <= CL_CHANGE;
          sse_q  <= ctr_q;
          ctr_q  <= pct_q;
          inb_q  <= '0;
          // Leaving half-cycle opens the change, so a one-half-cycle dip is still measured
          tcur_q <= mag16(dv) > THR ? 16'h0001 : 16'h0000;
          if (mag16(dv) > THR && over_threshold_time_q == 16'h0000) over_threshold_time_q <= 16'h0001;
          if (!dv[16] && dv[15:0] > dnx_q) dnx_q <= dv[15:0];
          if (dv[16] && mag16(dv) > upx_q) upx_q <= mag16(dv);
        end else begin
          ctr_q <= ref_v;
        end
      end else begin
        if (out_b) begin
          ctr_q <= pct_q;
          inb_q <= '0;
        end else if (inb_q + 7'h01 >= nhc) begin
          cls_q  <= CL_STEADY;
          ctr_q  <= ref_v;
          have_q <= 1'b1;
          if (have_q && mag16(17'(ref_v) - 17'(sse_q)) > dc_q) dc_q <= mag16(17'(ref_v) - 17'(sse_q));
        end else begin
          inb_q <= inb_q + 7'h01;
        end
        if (have_q) begin
          if (!dd[16] && dd[15:0] > dnx_q) dnx_q <= dd[15:0];
          if (dd[16] && mag16(dd) > upx_q) upx_q <= mag16(dd);
          if (mag16(dd) > THR) begin
            tcur_q <= tcur_q + 16'h0001;
            if (tcur_q + 16'h0001 > over_threshold_time_q) over_threshold_time_q <= tcur_q + 16'h0001;
          end
        end
      end
    end
  end

  // Results, pass flags and register read-back
  logic [15:0] max_relative_change_q;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      max_relative_change_q      <= '0;
      pass_out    <= 3'b111;
      steady_out  <= 1'b0;
      running_out <= 1'b0;
    end else begin
      max_relative_change_q      <= dnx_q > upx_q ? dnx_q : upx_q;
      pass_out[0] <= dc_q <= DC_LIM;
      pass_out[1] <= max_relative_change_q <= dlim_q;
      pass_out[2] <= over_threshold_time_q < tlim;
      steady_out  <= cls_q == CL_STEADY;
      running_out <= run_q;
    end
  end

  always_comb begin
    rd_d = '0;
    unique case (haddr_in[7:0])
      A_CTRL:  rd_d = 32'({cur_q, omit_q, f60_q, 2'b00});
      A_NOM:   rd_d = 32'(nom_q);
      A_DLIM:  rd_d = 32'(dlim_q);
      A_RANGE: rd_d = 32'(range_q);
      A_IMPR:  rd_d = 32'(impr_q);
      A_IMPX:  rd_d = 32'(impx_q);
      A_STAT:  rd_d = 32'({imp_rej_q, pass_out, cls_q == CL_STEADY, abort_q, done_q, run_q});
      A_DC:    rd_d = 32'(dc_q);
      A_MAX_RELATIVE_CHANGE:  rd_d = 32'(max_relative_change_q);
      A_OVER_THRESHOLD_TIME:  rd_d = 32'(over_threshold_time_q);
      A_SECS:  rd_d = 32'(secs_q);
      A_DNUP:  rd_d = {upx_q, dnx_q};
      default: rd_d = '0;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      hrdata_out    <= '0;
      hreadyout_out <= 1'b0;
      hresp_out     <= 1'b0;
    end else begin
      hrdata_out    <= (acc && !hwrite_in) ? rd_d : 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end

  range_lock_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    cur_q |=> ##1 range_out == RANGE_96) else $error("range not held at 96 A");
  ovl_abort_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    run_q && ovl_q && !start_q |=> !run_q && abort_q) else $error("overload did not abort");
  steady_entry_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    cls_go && run_q && !start_q && cls_q == CL_CHANGE && !out_b && inb_q + 7'h01 < nhc
    |=> cls_q == CL_CHANGE) else $error("steady declared too early");
  steady_exit_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    cls_go && run_q && !start_q && cls_q == CL_STEADY && out_b |=> cls_q == CL_CHANGE && sse_q == $past(ctr_q))
    else $error("steady state not ended");
  band_move_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    cls_q == CL_CHANGE && !(cls_go && run_q) && !start_q |=> $stable(ctr_q)) else $error("centre moved");
  dc_grow_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !start_q |=> dc_q >= $past(dc_q)) else $error("step result shrank");
  over_threshold_time_fail_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    over_threshold_time_q >= tlim && !start_q ##1 !start_q |=> !pass_out[2]) else $error("time limit not failed");
  dc_judge_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    dc_q > DC_LIM |=> !pass_out[0]) else $error("step limit not failed");
  imp_reject_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    wr_q && wa_q == A_IMPR && !imp_ok |=> imp_rej_q && $stable(impr_q)) else $error("bad impedance taken");
  duration_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    run_q |-> secs_q < dur) else $error("test ran past duration");
endmodule

// ---- vfa_front_model.sv ----
// Acquisition front end model: square-wave mains samples and the overload pin.
// Assumes the analyser takes one sample per smp_valid_out strobe on the same clock.
`timescale 1ns/10ps
module vfa_front_model (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic [15:0] amp_in,
  input  wire logic        ovl_in,
  output logic             smp_valid_out,
  output logic      [15:0] smp_out,
  output logic             overload_out
);
  logic [4:0] div_q;
  logic [3:0] cnt_q;
  logic       neg_q;

  assign overload_out = ovl_in;

  // Ten samples per half-cycle, one every twenty clocks; square wave so rms equals amplitude
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      div_q         <= 5'h00;
      cnt_q         <= 4'h0;
      neg_q         <= 1'b0;
      smp_valid_out <= 1'b0;
      smp_out       <= 16'h0000;
    end else if (div_q == 5'h13) begin
      div_q         <= 5'h00;
      smp_valid_out <= 1'b1;
      smp_out       <= neg_q ? 16'(~amp_in + 16'h0001) : amp_in;
      cnt_q         <= (cnt_q == 4'h9) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q == 4'h9) begin
        neg_q <= ~neg_q;
      end
    end else begin
      div_q         <= div_q + 5'h01;
      smp_valid_out <= 1'b0;
      smp_out       <= ~smp_out;
    end
  end
endmodule

// ---- vfa_top_tb.sv ----
// Self-checking bench of the fluctuation analyser: register map, steady/change analysis, abort.
// Assumes a zero-wait AHB-Lite slave and the square-wave front end model.
`timescale 1ns/10ps
module vfa_top_tb;
  import vfa_pkg::*;
  localparam int unsigned SEC = 100;
  logic        clk_sys_in;
  logic        rst_n_in;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        sv;
  logic [15:0] smp;
  logic        ovl;
  logic        ovl_pin;
  logic [15:0] amp;
  logic [7:0]  range;
  logic        vhi;
  logic        f60;
  logic [15:0] sdiv;
  logic        steady;
  logic        running;
  logic [2:0]  pass;
  int          error_cnt;
  int          check_count;
  int          cyc;

  vfa_top #(.SEC_CYC(SEC)) vfa_top_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .smp_valid_in(sv), .smp_in(smp), .overload_in(ovl_pin), .range_out(range), .vrange_hi_out(vhi),
    .filt_60_out(f60), .smp_div_out(sdiv), .steady_out(steady), .running_out(running), .pass_out(pass));
  vfa_front_model vfa_front_model_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .amp_in(amp),
    .ovl_in(ovl), .smp_valid_out(sv), .smp_out(smp), .overload_out(ovl_pin));

  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  task automatic final_report;
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      final_report;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One single transfer; trailing idle edges let a write land before the next access
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    rd = hrdata;
    repeat (3) @(posedge clk_sys_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h00000000, x);
    chk(nm, x, exp);
  endtask

  task automatic wait_steady(input logic lvl, input int lim);
    for (int n = 0; n < lim && steady !== lvl; n++) @(posedge clk_sys_in);
    chk("steady", steady, lvl);
  endtask

  task automatic t_reset;
    chk("range", range, 8'h60);
    chk("sdiv", sdiv, SDIV_50);
    chk("vhi", vhi, 1'b1);
    chk("pass", pass, 3'h7);
    chk("run", running, 1'b0);
    chk("hresp", hresp, 1'b0);
    rdc("nom", A_NOM, 32'h000008fc);
    rdc("dlim", A_DLIM, 32'h00000190);
    rdc("range_r", A_RANGE, 32'h00000060);
    rdc("impr", A_IMPR, 32'h00000190);
    rdc("impx", A_IMPX, 32'h000000fa);
    rdc("stat", A_STAT, 32'h00000070);
    rdc("unmapped", 8'h30, 32'h00000000);
  endtask

  task automatic t_config;
    wr(A_NOM, 32'h000004b0);
    chk("vhi_lo", vhi, 1'b0);
    wr(A_NOM, 32'h000008fc);
    chk("vhi_hi", vhi, 1'b1);
    wr(A_CTRL, 32'h00000004);
    chk("f60", f60, 1'b1);
    chk("sdiv60", sdiv, SDIV_60);
    rdc("ctrl", A_CTRL, 32'h00000004);
    wr(A_CTRL, 32'h00000010);
    wr(A_RANGE, 32'h00000032);
    rdc("range_cur", A_RANGE, 32'h00000060);
    chk("range_o", range, 8'h60);
    wr(A_CTRL, 32'h00000000);
    wr(A_RANGE, 32'h00000032);
    rdc("range_v", A_RANGE, 32'h00000032);
    chk("range_v_o", range, 8'h32);
    wr(A_RANGE, 32'h00000060);
    wr(A_IMPR, 32'h00000000);
    rdc("impr_rej", A_IMPR, 32'h00000190);
    rdc("stat_rej", A_STAT, 32'h000000f0);
    wr(A_IMPX, 32'h00000fa0);
    rdc("impx_max", A_IMPX, 32'h00000fa0);
    rdc("stat_ok", A_STAT, 32'h00000070);
    wr(A_IMPR, 32'h00000fa1);
    rdc("impr_over", A_IMPR, 32'h00000190);
    wr(A_IMPR, 32'h00000190);
    wr(A_DLIM, 32'h000001f4);
  endtask

  // Steady at nominal, 5.00 % drop, new steady, then the 600 s run ends by itself
  task automatic t_analyse;
    int st;
    logic [31:0] v;
    wr(A_CTRL, 32'h00000009);
    st = cyc;
    chk("running", running, 1'b1);
    wait_steady(1'b1, 30000);
    amp <= 16'h0889;
    wait_steady(1'b0, 2000);
    wait_steady(1'b1, 30000);
    amp <= 16'h08fc;
    wait_steady(1'b0, 2000);
    for (int n = 0; n < 70000 && running !== 1'b0; n++) @(posedge clk_sys_in);
    chk("dur", (cyc - st >= 59985 && cyc - st <= 60005), 1'b1);
    rdc("dc", A_DC, 32'h000001f4);
    rdc("max_relative_change", A_MAX_RELATIVE_CHANGE, 32'h000001f4);
    rdc("dnup", A_DNUP, 32'h01f401f4);
    rdc("secs", A_SECS, 32'h00000258);
    bus(1'b0, A_OVER_THRESHOLD_TIME, 32'h00000000, v);
    chk("over_threshold_time", v >= 32'h00000032, 1'b1);
    chk("pass_end", pass, 3'h2);
  endtask

  task automatic t_abort;
    logic [31:0] v;
    wr(A_CTRL, 32'h00000001);
    ovl <= 1'b1;
    for (int n = 0; n < 20 && running !== 1'b0; n++) @(posedge clk_sys_in);
    chk("run_abort", running, 1'b0);
    bus(1'b0, A_STAT, 32'h00000000, v);
    chk("abort", v[2], 1'b1);
    ovl <= 1'b0;
    wr(A_CTRL, 32'h00000002);
    bus(1'b0, A_STAT, 32'h00000000, v);
    chk("abort_clr", v[2], 1'b0);
  endtask

  initial begin
    rst_n_in    = 1'b0;
    hsel        = 1'b0;
    haddr       = 32'h00000000;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hwdata      = 32'h00000000;
    ovl         = 1'b0;
    amp         = 16'h08fc;
    error_cnt   = 0;
    check_count = 0;
    cyc         = 0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    t_reset;
    t_config;
    t_analyse;
    t_abort;
    final_report;
  end
endmodule
